// ### psmc_pkg.sv
// package: power saving mode control constants, types and carriers
package psmc_pkg;

    // power modes held by the mode state machine
    typedef enum logic [2:0] {
        PSMC_RUN,
        PSMC_SLOW_WAIT_OR_WAIT,
        PSMC_ACTIVE_HALT,
        PSMC_HALT,
        PSMC_STABILISE
    } psmc_mode_t;

    // ========================================================
    // register map (AXI4-Lite byte addresses)
    // ========================================================
    localparam logic [7:0] PSMC_ADDR_CTRL   = 8'h00;
    localparam logic [7:0] PSMC_ADDR_STATUS = 8'h04;

    // control register fields
    localparam int PSMC_CTRL_SLOW_BIT = 0;
    localparam int PSMC_CTRL_DIV_LSB  = 1;
    localparam int PSMC_CTRL_OIE_BIT  = 3;
    localparam logic [3:0] PSMC_CTRL_RESET = 4'h0;

    // status register fields
    localparam int PSMC_STAT_MODE_LSB = 0;
    localparam int PSMC_STAT_CPU_BIT  = 4;
    localparam int PSMC_STAT_PER_BIT  = 5;

    // ========================================================
    // fixed values
    // ========================================================
    localparam logic [1:0] PSMC_MASK_LEVEL_ON_ENTRY = 2'h2;
    localparam int PSMC_STAB_SHORT = 256;
    localparam int PSMC_STAB_LONG  = 4096;
    localparam int PSMC_CNT_W      = 13;
    localparam logic [1:0] PSMC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] PSMC_RESP_SLVERR = 2'h2;

    // wake-up causes from the interrupt logic
    typedef struct packed {
        logic ext_irq;
        logic timebase_irq;
        logic other_irq;
    } psmc_wake_t;

    // clock gating outputs toward the clock tree
    typedef struct packed {
        logic cpu_clk_en;
        logic periph_clk_en;
        logic osc_on;
        logic timebase_clk_en;
    } psmc_clk_t;

endpackage

// ### psmc_clkdiv.sv
// slow mode clock enable generator dividing the master clock
`timescale 1ns/1ps
module psmc_clkdiv (
    input  wire logic       clk_in,
    input  wire logic       rstn_in,
    input  wire logic       slow_en_in,
    input  wire logic [1:0] slow_divider_select_in,
    output logic            tick_out
);
    import psmc_pkg::*;

    logic [3:0] count;
    logic [3:0] limit;

    // limit picks divide by 2, 4, 8 or 16; shifted in 5 bits so /16 fits
    assign limit = 4'((5'h02 << slow_divider_select_in) - 5'h01);

    // free counter; tick once per divided period
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            count    <= 4'h0;
            tick_out <= 1'b1;
        end else if (!slow_en_in) begin
            count    <= 4'h0;
            tick_out <= 1'b1;
        end else begin
            count    <= (count >= limit) ? 4'h0 : count + 4'h1;
            tick_out <= (count >= limit);
        end
    end
endmodule

// ### psmc_stab.sv
// oscillator stabilisation delay counter
`timescale 1ns/1ps
module psmc_stab #(
    parameter int SHORT_CYCLES = psmc_pkg::PSMC_STAB_SHORT,
    parameter int LONG_CYCLES  = psmc_pkg::PSMC_STAB_LONG
) (
    input  wire logic clk_in,
    input  wire logic rstn_in,
    input  wire logic start_in,
    input  wire logic long_sel_in,
    output logic      busy_out,
    output logic      done_out
);
    import psmc_pkg::*;

    logic [PSMC_CNT_W-1:0] count;

    // load on start, count down, pulse done at zero
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            count    <= '0;
            busy_out <= 1'b0;
            done_out <= 1'b0;
        end else if (start_in) begin
            count    <= long_sel_in ? PSMC_CNT_W'(LONG_CYCLES - 1)
                                    : PSMC_CNT_W'(SHORT_CYCLES - 1);
            busy_out <= 1'b1;
            done_out <= 1'b0;
        end else if (busy_out) begin
            count    <= count - 1'b1;
            busy_out <= (count != '0);
            done_out <= (count == '0);
        end else begin
            done_out <= 1'b0;
        end
    end
endmodule

// ### psmc_top.sv
// power saving mode controller with AXI4-Lite register access
`timescale 1ns/1ps
module psmc_top #(
    parameter int STAB_SHORT = psmc_pkg::PSMC_STAB_SHORT,
    parameter int STAB_LONG  = psmc_pkg::PSMC_STAB_LONG
) (
    input  wire logic               clk_in,
    input  wire logic               rstn_in,
    // cpu side
    input  wire logic               wait_for_irq_instruction_in,
    input  wire logic               halt_instruction_in,
    input  wire logic               irq_pending_in,
    input  wire psmc_pkg::psmc_wake_t wake_in,
    input  wire logic               wake_reset_in,
    input  wire logic               stab_long_sel_in,
    input  wire logic               watchdog_reset_req_in,
    output logic                    mask_force_out,
    output logic [1:0]              mask_value_out,
    output logic                    vector_reset_out,
    output logic                    vector_irq_out,
    output psmc_pkg::psmc_clk_t     clk_ctrl_out,
    output logic                    cpu_tick_out,
    output logic                    watchdog_reset_out,
    // AXI4-Lite slave
    input  wire logic [7:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [7:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready
);
    import psmc_pkg::*;

    // ========================================================
    // register file
    // ========================================================
    logic       slow_mode_select;
    logic [1:0] slow_divider_select;
    logic       oscillator_irq_enable;
    psmc_mode_t mode;
    psmc_mode_t next_mode;
    logic       aw_held;
    logic       w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic       div_tick;
    logic       stab_start;
    logic       stab_busy;
    logic       stab_done;
    logic       stab_from_reset;
    logic       tb_guard;
    logic [PSMC_CNT_W-1:0] tb_guard_cnt;

    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire wr_ctrl  = do_write && (aw_addr == PSMC_ADDR_CTRL);
    wire rd_take  = s_axi_arvalid && s_axi_arready;
    wire [31:0] status_word = {26'h0, clk_ctrl_out.periph_clk_en,
                               clk_ctrl_out.cpu_clk_en, 1'b0, mode};
    wire [31:0] ctrl_word = {28'h0, oscillator_irq_enable,
                             slow_divider_select, slow_mode_select};
    wire rd_hit = (s_axi_araddr == PSMC_ADDR_CTRL) ||
                  (s_axi_araddr == PSMC_ADDR_STATUS);
    wire [31:0] rd_word = (s_axi_araddr == PSMC_ADDR_CTRL) ? ctrl_word
                                                            : status_word;

    // write channels taken in either order, answered once both are held
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= PSMC_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr == PSMC_ADDR_CTRL ||
                                 aw_addr == PSMC_ADDR_STATUS)
                                ? PSMC_RESP_OKAY : PSMC_RESP_SLVERR;
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read channel: one cycle accept, data the next
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= PSMC_RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready &&
                             !s_axi_rvalid;
            if (rd_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_hit ? rd_word : 32'h0;
                s_axi_rresp  <= rd_hit ? PSMC_RESP_OKAY : PSMC_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // control bits; byte lane 0 only, status is read-only
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            {oscillator_irq_enable, slow_divider_select,
             slow_mode_select} <= PSMC_CTRL_RESET;
        end else if (wr_ctrl && w_strb[0]) begin
            slow_mode_select      <= w_data[PSMC_CTRL_SLOW_BIT];
            slow_divider_select   <= w_data[PSMC_CTRL_DIV_LSB +: 2];
            oscillator_irq_enable <= w_data[PSMC_CTRL_OIE_BIT];
        end
    end

    // ========================================================
    // mode state machine
    // ========================================================
    // guard window after a timebase wake; clearing oie in it halts
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tb_guard     <= 1'b0;
            tb_guard_cnt <= '0;
        end else if (mode == PSMC_ACTIVE_HALT && wake_in.timebase_irq) begin
            tb_guard     <= 1'b1;
            tb_guard_cnt <= stab_long_sel_in
                            ? PSMC_CNT_W'(STAB_LONG - 1)
                            : PSMC_CNT_W'(STAB_SHORT - 1);
        end else if (tb_guard) begin
            tb_guard_cnt <= tb_guard_cnt - 1'b1;
            tb_guard     <= (tb_guard_cnt != '0);
        end
    end

    wire ah_wake = wake_in.ext_irq || wake_in.timebase_irq;
    wire h_wake  = ah_wake || wake_in.other_irq;
    wire oie_cleared_early = tb_guard && !oscillator_irq_enable;

    // next mode selection
    always_comb begin
        next_mode  = mode;
        stab_start = 1'b0;
        unique case (mode)
            PSMC_RUN: begin
                if (wait_for_irq_instruction_in && !irq_pending_in) begin
                    next_mode = PSMC_SLOW_WAIT_OR_WAIT;
                end else if (halt_instruction_in && !irq_pending_in) begin
                    next_mode = oscillator_irq_enable ? PSMC_ACTIVE_HALT
                                                      : PSMC_HALT;
                end else if (oie_cleared_early) begin
                    next_mode = PSMC_HALT;
                end
            end
            PSMC_SLOW_WAIT_OR_WAIT: begin
                if (irq_pending_in || h_wake) begin
                    next_mode = PSMC_RUN;
                end
            end
            PSMC_ACTIVE_HALT: begin
                if (wake_reset_in) begin
                    next_mode  = PSMC_STABILISE;
                    stab_start = 1'b1;
                end else if (ah_wake) begin
                    next_mode = PSMC_RUN;
                end
            end
            PSMC_HALT: begin
                if (wake_reset_in || h_wake) begin
                    next_mode  = PSMC_STABILISE;
                    stab_start = 1'b1;
                end else if (tb_guard && tb_guard_cnt == '0) begin
                    // an early oie clear halts only for the rest of the guard
                    next_mode = PSMC_RUN;
                end
            end
            PSMC_STABILISE: begin
                if (stab_done) begin
                    next_mode = PSMC_RUN;
                end
            end
            default: next_mode = PSMC_RUN;
        endcase
    end

    // state register and wake vector choice
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mode             <= PSMC_RUN;
            stab_from_reset  <= 1'b0;
            vector_reset_out <= 1'b0;
            vector_irq_out   <= 1'b0;
        end else begin
            mode <= next_mode;
            if (stab_start) begin
                stab_from_reset <= wake_reset_in;
            end
            vector_reset_out <= (next_mode == PSMC_RUN) &&
                                (mode == PSMC_STABILISE) && stab_from_reset;
            vector_irq_out   <= (next_mode == PSMC_RUN) && (mode != PSMC_RUN)
                                && !(mode == PSMC_STABILISE && stab_from_reset);
        end
    end

    // mask forced to 10 on wait or halt entry; service level is cpu's
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mask_force_out <= 1'b0;
            mask_value_out <= PSMC_MASK_LEVEL_ON_ENTRY;
        end else begin
            mask_force_out <= (mode == PSMC_RUN) &&
                              (next_mode != PSMC_RUN) &&
                              (next_mode != PSMC_STABILISE);
            mask_value_out <= PSMC_MASK_LEVEL_ON_ENTRY;
        end
    end

    // clock gating per mode; watchdog masked in active-halt while oie is set
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            clk_ctrl_out       <= '{1'b1, 1'b1, 1'b1, 1'b1};
            cpu_tick_out       <= 1'b1;
            watchdog_reset_out <= 1'b0;
        end else begin
            clk_ctrl_out.cpu_clk_en      <= (next_mode == PSMC_RUN);
            clk_ctrl_out.periph_clk_en   <= (next_mode == PSMC_RUN) ||
                (next_mode == PSMC_SLOW_WAIT_OR_WAIT);
            clk_ctrl_out.osc_on          <= (next_mode != PSMC_HALT);
            clk_ctrl_out.timebase_clk_en <= (next_mode != PSMC_HALT) &&
                                            (next_mode != PSMC_STABILISE);
            cpu_tick_out       <= div_tick;
            watchdog_reset_out <= watchdog_reset_req_in &&
                !(mode == PSMC_ACTIVE_HALT && oscillator_irq_enable);
        end
    end

    // ========================================================
    // submodules
    // ========================================================
    psmc_clkdiv u_div (
        .clk_in                 (clk_in),
        .rstn_in                (rstn_in),
        .slow_en_in             (slow_mode_select),
        .slow_divider_select_in (slow_divider_select),
        .tick_out               (div_tick)
    );

    psmc_stab #(
        .SHORT_CYCLES (STAB_SHORT),
        .LONG_CYCLES  (STAB_LONG)
    ) u_stab (
        .clk_in      (clk_in),
        .rstn_in     (rstn_in),
        .start_in    (stab_start),
        .long_sel_in (stab_long_sel_in),
        .busy_out    (stab_busy),
        .done_out    (stab_done)
    );

    // ========================================================
    // checks
    // ========================================================
    property p_ah_irq_fast;
        @(posedge clk_in) disable iff (!rstn_in)
        (mode == PSMC_ACTIVE_HALT && ah_wake && !wake_reset_in)
            |=> (mode == PSMC_RUN);
    endproperty
    a_ah_irq_fast: assert property (p_ah_irq_fast)
        else $error("active-halt irq exit not immediate");

    property p_halt_sel;
        @(posedge clk_in) disable iff (!rstn_in)
        (mode == PSMC_RUN && halt_instruction_in &&
         !wait_for_irq_instruction_in && !irq_pending_in)
            |=> (mode == (oscillator_irq_enable ? PSMC_ACTIVE_HALT
                                                 : PSMC_HALT));
    endproperty
    a_halt_sel: assert property (p_halt_sel)
        else $error("halt variant wrong for oie");

    property p_halt_stab;
        @(posedge clk_in) disable iff (!rstn_in)
        (mode == PSMC_HALT && h_wake) |=> (mode == PSMC_STABILISE)[*8];
    endproperty
    a_halt_stab: assert property (p_halt_stab)
        else $error("halt exit skipped stabilisation");

    property p_wait_cpu;
        @(posedge clk_in) disable iff (!rstn_in)
        (mode == PSMC_SLOW_WAIT_OR_WAIT) |=>
            (!clk_ctrl_out.cpu_clk_en || mode == PSMC_RUN);
    endproperty
    a_wait_cpu: assert property (p_wait_cpu)
        else $error("cpu clock on in wait");

    property p_mask;
        @(posedge clk_in) disable iff (!rstn_in)
        (mode == PSMC_RUN && next_mode == PSMC_SLOW_WAIT_OR_WAIT)
            |=> (mask_force_out && mask_value_out == 2'h2);
    endproperty
    a_mask: assert property (p_mask)
        else $error("mask not forced on wait entry");

    property p_wdg;
        @(posedge clk_in) disable iff (!rstn_in)
        (mode == PSMC_ACTIVE_HALT && oscillator_irq_enable)
            |=> !watchdog_reset_out;
    endproperty
    a_wdg: assert property (p_wdg)
        else $error("watchdog reset in active-halt");

    property p_ah_clk;
        @(posedge clk_in) disable iff (!rstn_in)
        (mode == PSMC_ACTIVE_HALT && $past(mode) == PSMC_ACTIVE_HALT) |->
            (!clk_ctrl_out.periph_clk_en && clk_ctrl_out.osc_on);
    endproperty
    a_ah_clk: assert property (p_ah_clk)
        else $error("active-halt clocks wrong");

    property p_ah_exit;
        @(posedge clk_in) disable iff (!rstn_in)
        (mode == PSMC_ACTIVE_HALT && !ah_wake && !wake_reset_in)
            |=> (mode == PSMC_ACTIVE_HALT);
    endproperty
    a_ah_exit: assert property (p_ah_exit)
        else $error("active-halt left without cause");

    property p_stab_busy;
        @(posedge clk_in) disable iff (!rstn_in)
        (mode == PSMC_STABILISE) |-> (stab_busy || stab_done);
    endproperty
    a_stab_busy: assert property (p_stab_busy)
        else $error("stabilise state without delay running");
endmodule

// ### psmc_cpu_model.sv
// cpu core model: issues power instructions and tracks the mask
`timescale 1ns/1ps
module psmc_cpu_model (
    input  wire logic       clk_in,
    input  wire logic       rstn_in,
    input  wire logic       do_wait_in,
    input  wire logic       do_halt_in,
    input  wire logic       mask_force_in,
    input  wire logic [1:0] mask_value_in,
    input  wire logic       vector_irq_in,
    input  wire logic       iret_in,
    output logic            wait_instr_out,
    output logic            halt_instr_out,
    output logic [1:0]      cc_mask_out
);
    logic [1:0] stacked;
    // ========================================================
    // instruction issue and interrupt mask
    // ========================================================
    // mask opens at level 3 so that a forced level stands out
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wait_instr_out <= 1'b0;
            halt_instr_out <= 1'b0;
            cc_mask_out <= 2'h3;
            stacked <= 2'h3;
        end else begin
            wait_instr_out <= do_wait_in;
            halt_instr_out <= do_halt_in;
            if (mask_force_in) begin
                cc_mask_out <= mask_value_in;
            end else if (vector_irq_in) begin
                stacked <= cc_mask_out;
                cc_mask_out <= 2'h3;
            end else if (iret_in) begin
                cc_mask_out <= stacked;
            end
        end
    end
endmodule

// ### power_saving_mode_control_bench.sv
// self-checking bench for the power saving mode controller
`timescale 1ns/1ps
module power_saving_mode_control_bench;
    import psmc_pkg::*;
    localparam int NS = 16;
    logic clk_in, mf, vrst, virq, tick, wdo, wait_for_irq_instruction, hlt, awr, wr, bv, arr, rv;
    logic rstn_in = 1'b0, dw = 1'b0, dh = 1'b0, iret = 1'b0, pend = 1'b0;
    logic wrst = 1'b0, wdq = 1'b0, awv = 1'b0, wv = 1'b0, brd = 1'b0;
    logic arv = 1'b0, rrd = 1'b0, lsel = 1'b0;
    logic [1:0] mv, cc, bresp, rresp;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rd;
    psmc_wake_t wk = 3'h0;
    psmc_clk_t ck;
    int err_total = 0, num_checks = 0, n;
    // ========================================================
    // clock, design and cpu model
    // ========================================================
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    psmc_top #(.STAB_SHORT(NS), .STAB_LONG(2 * NS)) i_dut (
        .clk_in(clk_in), .rstn_in(rstn_in),
        .wait_for_irq_instruction_in(wait_for_irq_instruction), .halt_instruction_in(hlt),
        .irq_pending_in(pend), .wake_in(wk), .wake_reset_in(wrst),
        .stab_long_sel_in(lsel), .watchdog_reset_req_in(wdq),
        .mask_force_out(mf), .mask_value_out(mv),
        .vector_reset_out(vrst), .vector_irq_out(virq),
        .clk_ctrl_out(ck), .cpu_tick_out(tick), .watchdog_reset_out(wdo),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rrd));
    psmc_cpu_model i_cpu (.clk_in(clk_in), .rstn_in(rstn_in),
        .do_wait_in(dw), .do_halt_in(dh), .mask_force_in(mf),
        .mask_value_in(mv), .vector_irq_in(virq), .iret_in(iret),
        .wait_instr_out(wait_for_irq_instruction), .halt_instr_out(hlt), .cc_mask_out(cc));
    // ========================================================
    // shared tasks
    // ========================================================
    task automatic chk(input string s, input logic [31:0] g, e);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %0h seen %0h", s, e, g);
        end
    endtask
    task automatic end_of_test();
        if (err_total == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic hang();
        err_total++;
        end_of_test();
    endtask
    // both channels offered at once, each dropped when taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       output logic [1:0] r);
        @(posedge clk_in);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        brd <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
            if (awr === 1'b1) awv <= 1'b0;
            if (wr === 1'b1) wv <= 1'b0;
        end while (bv !== 1'b1 && n < 99);
        r = bresp;
        brd <= 1'b0;
        if (bv !== 1'b1) hang();
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        @(posedge clk_in);
        ara <= a;
        arv <= 1'b1;
        rrd <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
            if (arr === 1'b1) arv <= 1'b0;
        end while (rv !== 1'b1 && n < 99);
        d = rd;
        r = rresp;
        rrd <= 1'b0;
        if (rv !== 1'b1) hang();
    endtask
    task automatic mode_is(input psmc_mode_t m);
        logic [31:0] d;
        logic [1:0] r;
        axr(PSMC_ADDR_STATUS, d, r);
        chk("mode", {29'h0, d[2:0]}, m);
    endtask
    // waits for the resume pulse; k is the cycles it took
    task automatic vec(input logic irq, output int k);
        for (k = 1; k < 200; k++) begin
            @(posedge clk_in);
            if ((irq ? virq : vrst) === 1'b1) break;
        end
        if (k == 200) hang();
    endtask
    task automatic ins(input logic h);
        dh <= h;
        dw <= ~h;
        @(posedge clk_in);
        dh <= 1'b0;
        dw <= 1'b0;
        repeat (4) @(posedge clk_in);
    endtask
    task automatic ticks(input int p);
        int c = 0;
        repeat (64) begin
            @(posedge clk_in);
            c += (tick === 1'b1);
        end
        chk("ticks", c, 64 / p);
    endtask
    // ========================================================
    // scenarios
    // ========================================================
    task automatic t_reset();
        logic [31:0] d;
        logic [1:0] r;
        axr(PSMC_ADDR_CTRL, d, r);
        chk("ctrl", d, {28'h0, PSMC_CTRL_RESET});
        axr(PSMC_ADDR_STATUS, d, r);
        chk("status", d, 32'h30);
        chk("clocks", ck, 4'hF);
        chk("tick", tick, 1'b1);
        axr(8'h08, d, r);
        chk("rresp", r, PSMC_RESP_SLVERR);
        axw(8'h0C, 32'h1, r);
        chk("bresp", r, PSMC_RESP_SLVERR);
    endtask
    // every divider, then wait on top of the slowest one
    task automatic t_slow();
        logic [1:0] r;
        for (int d = 0; d < 4; d++) begin
            axw(PSMC_ADDR_CTRL, 32'(2 * d + 1), r);
            repeat (8) @(posedge clk_in);
            ticks(2 << d);
        end
        ins(1'b0);
        mode_is(PSMC_SLOW_WAIT_OR_WAIT);
        ticks(16);
        chk("clocks", ck, 4'h7);
        chk("mask", cc, 2'h2);
        wk <= 3'h4;
        vec(1'b1, n);
        wk <= 3'h0;
        mode_is(PSMC_RUN);
        iret <= 1'b1;
        @(posedge clk_in);
        iret <= 1'b0;
        @(posedge clk_in);
        chk("mask", cc, 2'h2);
        axw(PSMC_ADDR_CTRL, 32'h0, r);
    endtask
    task automatic t_ahalt();
        logic [1:0] r;
        axw(PSMC_ADDR_CTRL, 32'h8, r);
        wdq <= 1'b1;
        repeat (2) @(posedge clk_in);
        chk("wdg", wdo, 1'b1);
        ins(1'b1);
        mode_is(PSMC_ACTIVE_HALT);
        chk("mask", cc, 2'h2);
        chk("clocks", ck, 4'h3);
        chk("wdg", wdo, 1'b0);
        wk <= 3'h1;
        repeat (6) @(posedge clk_in);
        mode_is(PSMC_ACTIVE_HALT);
        wdq <= 1'b0;
        wk <= 3'h2;
        vec(1'b1, n);
        wk <= 3'h0;
        chk("fast exit", n < NS, 1'b1);
        ins(1'b1);
        wrst <= 1'b1;
        vec(1'b0, n);
        wrst <= 1'b0;
        chk("reset exit", n >= NS, 1'b1);
        mode_is(PSMC_RUN);
    endtask
    task automatic t_halt();
        logic [1:0] r;
        axw(PSMC_ADDR_CTRL, 32'h0, r);
        for (int l = 0; l < 2; l++) begin
            lsel <= l[0];
            ins(1'b1);
            mode_is(PSMC_HALT);
            chk("clocks", ck, 4'h0);
            wk <= 3'h4;
            vec(1'b1, n);
            wk <= 3'h0;
            chk("stab", n >= (NS << l) && n <= (NS << l) + 8, 1'b1);
        end
    endtask
    // the enable is cleared well inside the guard time
    task automatic t_early();
        logic [31:0] d;
        logic [1:0] r;
        axw(PSMC_ADDR_CTRL, 32'h8, r);
        ins(1'b1);
        wk <= 3'h2;
        vec(1'b1, n);
        wk <= 3'h0;
        axw(PSMC_ADDR_CTRL, 32'h0, r);
        axr(PSMC_ADDR_STATUS, d, r);
        chk("early", d[2:0] inside {3'h3, 3'h4}, 1'b1);
        repeat (3 * NS) @(posedge clk_in);
        mode_is(PSMC_RUN);
    endtask
    task automatic t_pend();
        pend <= 1'b1;
        for (int h = 0; h < 2; h++) begin
            ins(h[0]);
            mode_is(PSMC_RUN);
        end
        pend <= 1'b0;
    endtask
    initial begin
        repeat (8) @(posedge clk_in);
        rstn_in <= 1'b1;
        t_reset();
        t_slow();
        t_ahalt();
        t_halt();
        t_early();
        t_pend();
        end_of_test();
    end
endmodule
